//--- design/cpu_decoder_map.svh
// Field positions, register numbers and reset values of the decode/execute unit.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CPU_DECODER_MAP_SVH
`define CPU_DECODER_MAP_SVH
`define F_OP 31:27
`define F_RD 26:22
`define F_RS 21:17
`define F_RT 16:12
`define F_SH 11:7
`define F_IMM 16:0
`define IMM_SIGN 16
`define F_JIMM 25:0
`define JIMM_SIGN 25
`define PC_KEEP 31:26
`define REG_ZERO 5'h00
`define REG_SOUND 5'h1B
`define REG_KEY 5'h1C
`define REG_STACK 5'h1D
`define REG_EPC 5'h1E
`define REG_RET 5'h1F
`define WORD_ZERO 32'h00000000
`define WORD_ONES 32'hFFFFFFFF
`define LOC_FILL 16'hFFFF
`define STACK_RESET 32'h0000FFFF
`define PC_STEP 32'h00000001
`endif

//--- design/cpu_decoder_pkg.sv
// Types shared by the decode/execute unit and its surroundings.
// Assumes the map header is on the include path.
`include "cpu_decoder_map.svh"
package cpu_decoder_pkg;
   typedef enum logic [4:0] {
      OP_ADD = 5'b00000, OP_ADDI = 5'b00001, OP_SUB = 5'b00010,
      OP_AND = 5'b00011, OP_ANDI = 5'b00100, OP_NAND = 5'b00101,
      OP_XOR = 5'b00110, OP_OR = 5'b00111, OP_SLL = 5'b01000,
      OP_SRL = 5'b01001, OP_B = 5'b01010, OP_BEQ = 5'b01011,
      OP_BNE = 5'b01100, OP_BLT = 5'b01101, OP_JR = 5'b01110,
      OP_CALL = 5'b01111, OP_RET = 5'b10000, OP_LW = 5'b10001,
      OP_LI = 5'b10010, OP_POP = 5'b10011, OP_PUSH = 5'b10100,
      OP_SW = 5'b10101, OP_SLOAD = 5'b10110, OP_SREMOVE = 5'b10111,
      OP_SLOC = 5'b11000, OP_STILE = 5'b11001, OP_BGTILE = 5'b11010,
      OP_SATTR = 5'b11011, OP_BGATTR = 5'b11100, OP_NOP = 5'b11101
   } opcode_e;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } state_e;
   typedef struct packed {
      logic valid;
      logic [31:0] pc;
      logic [31:0] word;
   } fetch_s;
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_s;
   typedef struct packed {
      logic valid;
      logic [31:0] target;
   } redirect_s;
   typedef struct packed {
      logic valid;
      logic [4:0] op;
      logic [9:0] index;
      logic [31:0] data;
   } ppu_cmd_s;
   typedef struct packed {
      logic v;
      logic n;
      logic z;
   } flags_s;
endpackage : cpu_decoder_pkg

//--- design/custom_isa_cpu_decoder.sv
// Decode/execute unit of the 32-bit core: register file, flags, stack pointer,
// branch resolution and hand-off of sprite instructions to the picture unit.
// Assumes fetch holds its word while busy, and memory answers reads in order.
`include "cpu_decoder_map.svh"
module custom_isa_cpu_decoder
   import cpu_decoder_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire fetch_s fetchIn,
   input wire logic irqTake,
   input wire logic keyValid,
   input wire logic [7:0] keyByte,
   input wire logic memRdValid,
   input wire logic [31:0] memRdData,
   output logic busy_r,
   output mem_req_s memReq_r,
   output redirect_s redirect_r,
   output ppu_cmd_s ppuCmd_r,
   output flags_s flags_r,
   output logic illegal_r
);
   logic [31:0] regs_r [32];
   logic [31:0] regsNxt [32];
   state_e state_r;
   state_e stateNxt;
   opcode_e pendOp_r;
   opcode_e pendOpNxt;
   logic [4:0] pendRd_r;
   logic [4:0] pendRdNxt;
   logic busyNxt;
   logic illegalNxt;
   mem_req_s memReqNxt;
   redirect_s redirectNxt;
   ppu_cmd_s ppuCmdNxt;
   flags_s flagsNxt;
   opcode_e op;
   logic [4:0] rdIdx;
   logic [4:0] rsIdx;
   logic [4:0] rtIdx;
   logic [31:0] srcA;
   logic [31:0] srcB;
   logic [31:0] rdVal;
   logic [31:0] immExt;
   logic [31:0] branchOffset;
   logic [31:0] stackTop;
   logic [31:0] pcNext;
   logic [31:0] branchTarget;
   logic [31:0] result;
   logic issue;

   function automatic logic [31:0] readReg(input logic [4:0] idx);
      readReg = (idx == `REG_ZERO) ? `WORD_ZERO : regs_r[idx];
   endfunction : readReg

   function automatic logic isSprite(input opcode_e o);
      isSprite = (o >= OP_SLOAD) && (o <= OP_BGATTR);
   endfunction : isSprite

   function automatic flags_s logicFlags(input logic [31:0] r);
      logicFlags.v = 1'b0;
      logicFlags.n = r[31];
      logicFlags.z = (r == `WORD_ZERO);
   endfunction : logicFlags

   assign op = opcode_e'(fetchIn.word[`F_OP]);
   assign rdIdx = fetchIn.word[`F_RD];
   assign rsIdx = fetchIn.word[`F_RS];
   assign rtIdx = fetchIn.word[`F_RT];
   // Not an assign: the register file is read inside the function and must wake the reads
   always_comb
   begin
      srcA = readReg(rsIdx);
      srcB = readReg(rtIdx);
      rdVal = readReg(rdIdx);
   end
   assign immExt = {{15{fetchIn.word[`IMM_SIGN]}}, fetchIn.word[`F_IMM]};
   assign branchOffset = {{6{fetchIn.word[`JIMM_SIGN]}}, fetchIn.word[`F_JIMM]};
   assign stackTop = regs_r[`REG_STACK];
   assign pcNext = fetchIn.pc + `PC_STEP;
   assign branchTarget = pcNext + branchOffset;
   // Interrupt takes priority so the fetched instruction is replayed, not doubled
   assign issue = fetchIn.valid && (state_r == ST_IDLE) && !irqTake;

   always_comb
   begin
      regsNxt = regs_r;
      stateNxt = state_r;
      pendOpNxt = pendOp_r;
      pendRdNxt = pendRd_r;
      flagsNxt = flags_r;
      memReqNxt = '0;
      redirectNxt = '0;
      ppuCmdNxt = '0;
      illegalNxt = 1'b0;
      result = `WORD_ZERO;
      if (issue)
      begin
         case (op)
            OP_ADD, OP_ADDI:
            begin
               result = srcA + ((op == OP_ADDI) ? immExt : srcB);
               regsNxt[rdIdx] = result;
               flagsNxt = logicFlags(result);
               flagsNxt.v = (srcA[31] == ((op == OP_ADDI) ? immExt[31] : srcB[31]))
                  && (result[31] != srcA[31]);
            end
            OP_SUB:
            begin
               result = srcA - srcB;
               regsNxt[rdIdx] = result;
               flagsNxt = logicFlags(result);
               flagsNxt.v = (srcA[31] != srcB[31]) && (result[31] != srcA[31]);
            end
            OP_AND, OP_ANDI, OP_NAND, OP_OR, OP_XOR:
            begin
               case (op)
                  OP_AND: result = srcA & srcB;
                  OP_ANDI: result = srcA & immExt;
                  OP_NAND: result = ~(srcA & srcB);
                  OP_OR: result = srcA | srcB;
                  default: result = srcA ^ srcB;
               endcase
               regsNxt[rdIdx] = result;
               flagsNxt = logicFlags(result);
            end
            OP_SLL:
            begin
               regsNxt[rdIdx] = srcA << fetchIn.word[`F_SH];
            end
            OP_SRL:
            begin
               regsNxt[rdIdx] = srcA >> fetchIn.word[`F_SH];
            end
            OP_B, OP_BEQ, OP_BNE, OP_BLT:
            begin
               case (op)
                  OP_B: redirectNxt.valid = 1'b1;
                  OP_BEQ: redirectNxt.valid = flags_r.z;
                  OP_BNE: redirectNxt.valid = !flags_r.z;
                  default: redirectNxt.valid = flags_r.n && !flags_r.v;
               endcase
               redirectNxt.target = branchTarget;
            end
            OP_JR:
            begin
               redirectNxt.valid = 1'b1;
               redirectNxt.target = srcA;
            end
            OP_CALL:
            begin
               redirectNxt.valid = 1'b1;
               redirectNxt.target = {fetchIn.pc[`PC_KEEP], fetchIn.word[`F_JIMM]};
               memReqNxt = '{valid: 1'b1, write: 1'b1, addr: stackTop, wdata: pcNext};
               regsNxt[`REG_STACK] = stackTop - `PC_STEP;
            end
            OP_RET, OP_POP:
            begin
               regsNxt[`REG_STACK] = stackTop + `PC_STEP;
               memReqNxt = '{valid: 1'b1, write: 1'b0, addr: stackTop + `PC_STEP,
                  wdata: `WORD_ZERO};
               stateNxt = ST_WAIT;
               pendOpNxt = op;
               pendRdNxt = rdIdx;
            end
            OP_LW:
            begin
               memReqNxt = '{valid: 1'b1, write: 1'b0, addr: srcA + immExt,
                  wdata: `WORD_ZERO};
               stateNxt = ST_WAIT;
               pendOpNxt = op;
               pendRdNxt = rdIdx;
            end
            OP_LI:
            begin
               regsNxt[rdIdx] = immExt;
            end
            OP_PUSH:
            begin
               memReqNxt = '{valid: 1'b1, write: 1'b1, addr: stackTop, wdata: rdVal};
               regsNxt[`REG_STACK] = stackTop - `PC_STEP;
            end
            OP_SW:
            begin
               memReqNxt = '{valid: 1'b1, write: 1'b1, addr: srcA + immExt,
                  wdata: rdVal};
            end
            OP_SLOAD, OP_SREMOVE, OP_SLOC, OP_STILE, OP_BGTILE, OP_SATTR, OP_BGATTR:
            begin
               ppuCmdNxt.valid = 1'b1;
               ppuCmdNxt.op = op;
               ppuCmdNxt.index = {4'h0, rdVal[5:0]};
               case (op)
                  OP_SLOAD: ppuCmdNxt.data = srcA;
                  OP_SREMOVE: ppuCmdNxt.data = `WORD_ONES;
                  OP_SLOC: ppuCmdNxt.data = {srcA[15:8], `LOC_FILL, srcA[7:0]};
                  OP_BGATTR: ppuCmdNxt.data = {30'h0, srcA[1:0]};
                  default: ppuCmdNxt.data = {24'h0, srcA[7:0]};
               endcase
               if (op == OP_BGTILE || op == OP_BGATTR)
               begin
                  ppuCmdNxt.index = rdVal[9:0];
               end
            end
            OP_NOP:
            begin
               illegalNxt = 1'b0;
            end
            default:
            begin
               illegalNxt = 1'b1;
            end
         endcase
      end
      else if (state_r == ST_WAIT && memRdValid)
      begin
         stateNxt = ST_IDLE;
         if (pendOp_r == OP_RET)
         begin
            redirectNxt = '{valid: 1'b1, target: memRdData};
         end
         else
         begin
            regsNxt[pendRd_r] = memRdData;
         end
      end
      if (keyValid)
      begin
         regsNxt[`REG_KEY] = {24'h0, keyByte};
      end
      if (irqTake)
      begin
         regsNxt[`REG_EPC] = fetchIn.pc;
      end
      regsNxt[`REG_ZERO] = `WORD_ZERO;
      busyNxt = (stateNxt == ST_WAIT);
   end

   // Register 27 and 31 are ordinary storage; software owns their meaning
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         regs_r <= '{default: `WORD_ZERO};
         regs_r[`REG_STACK] <= `STACK_RESET;
         state_r <= ST_IDLE;
         pendOp_r <= OP_NOP;
         pendRd_r <= `REG_ZERO;
         busy_r <= 1'b0;
         memReq_r <= '0;
         redirect_r <= '0;
         ppuCmd_r <= '0;
         flags_r <= '0;
         illegal_r <= 1'b0;
      end
      else
      begin
         regs_r <= regsNxt;
         state_r <= stateNxt;
         pendOp_r <= pendOpNxt;
         pendRd_r <= pendRdNxt;
         busy_r <= busyNxt;
         memReq_r <= memReqNxt;
         redirect_r <= redirectNxt;
         ppuCmd_r <= ppuCmdNxt;
         flags_r <= flagsNxt;
         illegal_r <= illegalNxt;
      end
   end

   zero_reg_a: assert property (@(posedge clk) disable iff (reset)
      ##1 readReg(`REG_ZERO) == `WORD_ZERO && regs_r[0] == `WORD_ZERO)
      else $error("register zero not zero");
   push_stack_a: assert property (@(posedge clk) disable iff (reset)
      issue && op == OP_PUSH |=> memReq_r.write && memReq_r.addr == $past(stackTop)
      && regs_r[`REG_STACK] == $past(stackTop) - `PC_STEP)
      else $error("push stack update wrong");
   pop_read_a: assert property (@(posedge clk) disable iff (reset)
      issue && op == OP_POP |=> memReq_r.valid && !memReq_r.write
      && memReq_r.addr == $past(stackTop) + `PC_STEP && busy_r)
      else $error("pop read address wrong");
   epc_save_a: assert property (@(posedge clk) disable iff (reset)
      irqTake |=> regs_r[`REG_EPC] == $past(fetchIn.pc) && !ppuCmd_r.valid)
      else $error("fetch pc not saved");
   key_save_a: assert property (@(posedge clk) disable iff (reset)
      keyValid |=> regs_r[`REG_KEY] == {24'h0, $past(keyByte)})
      else $error("key byte not saved");
   beq_taken_a: assert property (@(posedge clk) disable iff (reset)
      issue && op == OP_BEQ && flags_r.z |=> redirect_r.valid
      && redirect_r.target == $past(branchTarget))
      else $error("beq not taken");
   bne_hold_a: assert property (@(posedge clk) disable iff (reset)
      issue && op == OP_BNE && flags_r.z |=> !redirect_r.valid)
      else $error("bne taken on zero");
   blt_cond_a: assert property (@(posedge clk) disable iff (reset)
      issue && op == OP_BLT |=> redirect_r.valid == $past(flags_r.n && !flags_r.v))
      else $error("blt condition wrong");
   sprite_out_a: assert property (@(posedge clk) disable iff (reset)
      issue && isSprite(op) |=> ppuCmd_r.valid && !memReq_r.valid && !redirect_r.valid)
      else $error("sprite not handed off");
   bad_op_a: assert property (@(posedge clk) disable iff (reset)
      issue && op inside {5'b11110, 5'b11111} |=> illegal_r)
      else $error("undefined opcode not flagged");
   shift_flags_a: assert property (@(posedge clk) disable iff (reset)
      issue && op inside {OP_SLL, OP_SRL} |=> $stable(flags_r))
      else $error("shift changed flags");
   wait_done_a: assert property (@(posedge clk) disable iff (reset)
      state_r == ST_WAIT && memRdValid && pendOp_r == OP_RET |=> redirect_r.valid
      && redirect_r.target == $past(memRdData) && !busy_r)
      else $error("ret target wrong");
endmodule : custom_isa_cpu_decoder

//--- tb/mem_model.sv
// Main memory partner: keeps written words and answers each read after a set lag.
// Assumes at most one read outstanding, as the decoder issues them.
module mem_model
   import cpu_decoder_pkg::*;
(
   input wire logic clk,
   input wire mem_req_s memReq,
   input wire logic [2:0] lag,
   output logic rdValid,
   output logic [31:0] rdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [logic [31:0]];
   logic [31:0] addr = '0;
   int cnt = -1;
   initial rdValid = 1'b0;
   initial rdData = '0;
   always @(negedge clk)
   begin
      rdValid <= 1'b0;
      // Idle data toggles so a stale word is never mistaken for an answer
      rdData <= ~rdData;
      if (memReq.valid && memReq.write)
         mem[memReq.addr] = memReq.wdata;
      if (memReq.valid && !memReq.write)
      begin
         addr = memReq.addr;
         cnt = lag;
      end
      if (cnt == 0)
      begin
         rdValid <= 1'b1;
         // Unwritten words read as the inverted address
         rdData <= mem.exists(addr) ? mem[addr] : ~addr;
      end
      if (cnt >= 0)
         cnt = cnt - 1;
   end
endmodule : mem_model

//--- tb/tb.sv
// Testbench: a reference model of the instruction set checks every result.
// Assumes the decoder takes one offer per cycle and loads are awaited via busy.
module tb
   import cpu_decoder_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, irqTake, keyValid, memRdValid, busy_r, illegal_r;
   logic [7:0] keyByte;
   logic [31:0] memRdData, pc;
   logic [2:0] lag;
   fetch_s fetchIn;
   mem_req_s memReq_r, eMem;
   redirect_s redirect_r, eRed;
   ppu_cmd_s ppuCmd_r, ePpu;
   flags_s flags_r, eFlg;
   logic [31:0] regs [32];
   logic [31:0] mem [logic [31:0]];
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   custom_isa_cpu_decoder custom_isa_cpu_decoder_inst (.clk(clk), .reset(reset),
      .fetchIn(fetchIn), .irqTake(irqTake), .keyValid(keyValid), .keyByte(keyByte),
      .memRdValid(memRdValid), .memRdData(memRdData), .busy_r(busy_r), .memReq_r(memReq_r),
      .redirect_r(redirect_r), .ppuCmd_r(ppuCmd_r), .flags_r(flags_r), .illegal_r(illegal_r));
   mem_model mem_model_inst (.clk(clk), .memReq(memReq_r), .lag(lag), .rdValid(memRdValid),
      .rdData(memRdData));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic final_report();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         final_report();
      end
   end
   task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got,
      input logic [127:0] mask);
      comparisons++;
      if ((got & mask) !== (exp & mask))
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp & mask, got & mask);
      end
   endtask : check
   // Offers one instruction, compares every output against the model (busy only for reads), then retires it
   task automatic ex(input logic [31:0] w, input logic irq = 1'b0);
      logic [4:0] op, d;
      logic [31:0] a, b, r, im;
      logic [65:0] mm;
      logic [47:0] pm;
      logic wr, ill;
      int i;
      op = irq ? OP_NOP : w[31:27];
      ill = !irq && w[31:27] > 5'h1D;
      d = w[26:22];
      a = regs[w[21:17]];
      b = regs[w[16:12]];
      im = {{15{w[16]}}, w[16:0]};
      eMem = '0;
      eRed = '0;
      ePpu = '0;
      wr = 1'b0;
      r = '0;
      case (op)
         OP_ADD, OP_ADDI, OP_SUB:
         begin
            b = (op == OP_ADDI) ? im : b;
            r = (op == OP_SUB) ? a - b : a + b;
            eFlg.v = (r[31] != a[31]) && ((a[31] == b[31]) ^ (op == OP_SUB));
            eFlg.n = r[31];
            eFlg.z = (r == 32'h0);
            wr = 1'b1;
         end
         OP_AND, OP_ANDI, OP_NAND, OP_XOR, OP_OR:
         begin
            b = (op == OP_ANDI) ? im : b;
            r = (op == OP_XOR) ? a ^ b : (op == OP_OR) ? a | b : (op == OP_NAND) ? ~(a & b) : a & b;
            eFlg = {1'b0, r[31], r == 32'h0};
            wr = 1'b1;
         end
         OP_SLL, OP_SRL:
         begin
            r = (op == OP_SLL) ? a << w[11:7] : a >> w[11:7];
            wr = 1'b1;
         end
         OP_LI:
         begin
            r = im;
            wr = 1'b1;
         end
         OP_B, OP_BEQ, OP_BNE, OP_BLT:
            eRed = {op == OP_B || (op == OP_BEQ && eFlg.z) || (op == OP_BNE && !eFlg.z)
               || (op == OP_BLT && eFlg.n && !eFlg.v), pc + 32'h1 + {{6{w[25]}}, w[25:0]}};
         OP_JR:
            eRed = {1'b1, a};
         OP_CALL:
         begin
            eRed = {1'b1, pc[31:26], w[25:0]};
            eMem = {2'b11, regs[29], pc + 32'h1};
            regs[29] = regs[29] - 32'h1;
         end
         OP_PUSH:
         begin
            eMem = {2'b11, regs[29], regs[d]};
            regs[29] = regs[29] - 32'h1;
         end
         OP_POP, OP_RET:
         begin
            regs[29] = regs[29] + 32'h1;
            eMem = {2'b10, regs[29], 32'h0};
         end
         OP_LW:
            eMem = {2'b10, a + im, 32'h0};
         OP_SW:
            eMem = {2'b11, a + im, regs[d]};
         OP_SLOAD, OP_SREMOVE, OP_SLOC, OP_STILE, OP_BGTILE, OP_SATTR, OP_BGATTR:
            ePpu = {1'b1, op, (op == OP_BGTILE || op == OP_BGATTR) ? regs[d][9:0]
               : {4'h0, regs[d][5:0]}, (op == OP_SLOC) ? {a[15:8], 16'hFFFF, a[7:0]}
               : (op == OP_SREMOVE) ? 32'hFFFFFFFF : (op == OP_SLOAD) ? a
               : (op == OP_BGATTR) ? {30'h0, a[1:0]} : {24'h0, a[7:0]}};
         default: ;
      endcase
      // A read request carries no store data, so that field is masked out
      mm = !eMem.valid ? {1'b1, 65'h0} : {34'h3FFFFFFFF, {32{eMem.write}}};
      pm = !ePpu.valid ? {1'b1, 47'h0} : {48{1'b1}};
      fetchIn = {1'b1, pc, w};
      if (irq)
         irqTake = 1'b1;
      @(negedge clk);
      if (irq)
         irqTake = 1'b0;
      check("memReq", eMem, memReq_r, mm);
      check("redirect", eRed, redirect_r, eRed.valid ? '1 : {1'b1, 32'h0});
      check("ppuCmd", ePpu, ppuCmd_r, pm);
      check("flags", eFlg, flags_r, 3'h7);
      check("illegal", ill, illegal_r, 1'b1);
      if (eMem.valid && eMem.write)
         mem[eMem.addr] = eMem.wdata;
      if (wr && d != 5'h0)
         regs[d] = r;
      if (irq)
         regs[30] = pc;
      if (eMem.valid && !eMem.write)
      begin
         fetchIn.valid = 1'b0;
         check("busy", 1'b1, busy_r, 1'b1);
         for (i = 0; i < 20 && busy_r === 1'b1; i++)
            @(negedge clk);
         r = mem.exists(eMem.addr) ? mem[eMem.addr] : ~eMem.addr;
         check("busy", 1'b0, busy_r, 1'b1);
         if (op == OP_RET)
            check("redirect", {1'b1, r}, redirect_r, '1);
         else if (d != 5'h0)
            regs[d] = r;
      end
      pc = pc + 32'h1;
   endtask : ex
   initial
   begin
      fetchIn = '0;
      irqTake = 1'b0;
      keyValid = 1'b0;
      keyByte = 8'h00;
      lag = 3'h0;
      reset = 1'b1;
      pc = 32'h00000100;
      foreach (regs[i])
         regs[i] = '0;
      regs[29] = 32'h0000FFFF;
      eFlg = '0;
      void'($urandom(32'h8DD9));
      repeat (10) @(negedge clk);
      reset = 1'b0;
      check("busy", 1'b0, busy_r, 1'b1);
      for (int i = 0; i < 32; i++)
         if (i != 29)
            ex({OP_LI, 5'(i), 5'h0, 17'($urandom)});
      for (int i = 0; i < 32; i++)
         ex({OP_PUSH, 5'(i), 22'h0});
      $display("Test register file done");
      repeat (10)
         for (int k = 0; k < 32; k++)
         begin
            lag = 3'($urandom_range(0, 4));
            ex({5'(k), 27'($urandom)});
         end
      $display("Test instruction mix done");
      ex($urandom, 1'b1);
      ex({OP_PUSH, 5'h1E, 22'h0});
      fetchIn.valid = 1'b0;
      keyByte = 8'($urandom);
      keyValid = 1'b1;
      @(negedge clk);
      keyValid = 1'b0;
      regs[28] = {24'h0, keyByte};
      ex({OP_PUSH, 5'h1C, 22'h0});
      $display("Test interrupt and key done");
      final_report();
   end
endmodule : tb
